// *** design/sst_regs.vh ***
// Register offsets, field positions, reset values and widths of the system timer
`ifndef SST_REGS_VH
`define SST_REGS_VH
// ***********************************************************
// Register byte offsets
// ***********************************************************
`define SST_OFF_CLC      8'h00
`define SST_OFF_RSTREQ   8'h04
`define SST_OFF_WIN0     8'h10
`define SST_OFF_WIN6     8'h28
`define SST_OFF_CAP      8'h2c
`define SST_OFF_CMP0     8'h30
`define SST_OFF_CMP1     8'h34
`define SST_OFF_IRQSTAT  8'h38
`define SST_OFF_IRQMASK  8'h3c
// ***********************************************************
// Field positions
// ***********************************************************
`define SST_CLC_DIS_REQ  0
`define SST_CLC_DIS_STAT 1
`define SST_CLC_SUSP_EN  3
`define SST_CLC_DIV_LO   8
`define SST_CLC_DIV_HI   10
`define SST_RSTREQ_BIT   0
`define SST_IRQ_CMP0     0
`define SST_IRQ_CMP1     1
// ***********************************************************
// Reset values and widths
// ***********************************************************
`define SST_DIV_RESET    3'h2
`define SST_CNT_W        56
`define SST_WIN_STEP     4
`define SST_WIN6_SHIFT   32
`endif

// *** design/sst_tick.v ***
// Tick generator dividing the system clock by the timer clock divide field
`timescale 1ns/10ps
module sst_tick #(
  parameter DIV_W = 3
) (
  // Clock and power-on reset
  input  wire             pclk,
  input  wire             por_n,
  // Control
  input  wire             clear,
  input  wire             run,
  input  wire [DIV_W-1:0] div,
  // Tick out
  output reg              tick
);
  reg [DIV_W-1:0] pre_reg;
  reg [DIV_W-1:0] pre_next;
  wire            last;

  // Prescaler wraps after div cycles; a divide value of zero gives no tick
  assign last = (pre_reg >= div - {{(DIV_W-1){1'b0}}, 1'b1});

  // Next prescaler value
  always @* begin
    pre_next = pre_reg;
    if (clear || !run || div == {DIV_W{1'b0}}) begin
      pre_next = {DIV_W{1'b0}};
    end else if (last) begin
      pre_next = {DIV_W{1'b0}};
    end else begin
      pre_next = pre_reg + {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end

  // Prescaler and tick flops
  always @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      pre_reg <= {DIV_W{1'b0}};
      tick    <= 1'b0;
    end else begin
      pre_reg <= pre_next;
      tick    <= run && !clear && (div != {DIV_W{1'b0}}) && last;
    end
  end
endmodule // sst_tick

// *** design/sst_cmp.v ***
// Compare unit giving a one-cycle match event when the counter reaches a compare value
`timescale 1ns/10ps
module sst_cmp #(
  parameter W = 32
) (
  // Clock and reset
  input  wire         pclk,
  input  wire         por_n,
  // Operands
  input  wire [W-1:0] value,
  input  wire [W-1:0] cmp,
  // Event out
  output reg          hit
);
  reg  eq_reg;
  wire eq;

  assign eq = (value == cmp);

  // Event on the rising edge of equality so a held match fires once
  always @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      eq_reg <= 1'b0;
      hit    <= 1'b0;
    end else begin
      eq_reg <= eq;
      hit    <= eq && !eq_reg;
    end
  end
endmodule // sst_cmp

// *** design/sst_top.v ***
// System timer: free-running 56-bit counter with read windows, capture, compares and APB slave
//
// What this block does
// RQ1: 56-bit counter, +1 per tick, no loading
// RQ2: Tick is system clock over 3-bit divider, reset 010
// RQ3: Cleared by power-on, watchdog, requested software reset
// RQ4: Hardware reset pin spares counter and divider
// RQ5: Counting restarts at once after any clear
// RQ6: Value registers read-only, writes ignored
// RQ7: Disable and debug suspend via clock control
// RQ8: Reading windows 0-5 latches upper part
// RQ9: Software reads lower window, then capture register
// RQ10: Seven 32-bit windows of rising order
// RQ11: Two compare values raise match interrupts
// RQ12: Window N is bits 4N+31:4N, last 55:32
// RQ13: All-ones wraps to zero, no overflow event
`timescale 1ns/10ps
`include "sst_regs.vh"
module sst_top #(
  parameter DIV_W = 3
) (
  // APB slave, presetn is the hardware reset pin
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // System resets that clear the counter
  input  wire        por_n,
  input  wire        wdt_rst,
  input  wire        sw_rst,
  // Debug suspend request pin
  input  wire        debug_suspend,
  // Interrupt
  output reg         irq
);
  // ***********************************************************
  // Declarations
  // ***********************************************************
  reg  [`SST_CNT_W-1:0] cnt_reg;
  reg  [`SST_CNT_W-1:0] cnt_next;
  reg  [DIV_W-1:0]      div_reg;
  reg                   dis_reg;
  reg                   susp_en_reg;
  reg                   rstreq_reg;
  reg  [23:0]           cap_reg;
  reg  [31:0]           cmp0_reg;
  reg  [31:0]           cmp1_reg;
  reg  [1:0]            stat_reg;
  reg  [1:0]            stat_next;
  reg  [1:0]            mask_reg;
  reg  [1:0]            stat_rd_reg;
  reg  [2:0]            susp_sync_reg;
  reg                   susp_reg;
  reg  [31:0]           rdata;
  reg                   rd_hit;
  reg                   rd_win;
  wire                  setup;
  wire                  done;
  wire                  wr;
  wire                  cnt_clear;
  wire                  run;
  wire                  tick;
  wire                  hit0;
  wire                  hit1;
  wire [2:0]            win_idx;
  wire [`SST_CNT_W-1:0] win_shift;
  wire [`SST_CNT_W-1:0] win_val;

  // ***********************************************************
  // APB phase decode
  // ***********************************************************
  // Setup and completing access; windows 0-5 are indexed from the word at 0x10
  assign setup   = psel && !penable;
  assign done    = psel && penable && pready;
  assign wr      = done && pwrite;
  assign win_idx = paddr[4:2] - 3'h4;

  // ***********************************************************
  // Debug suspend pin synchroniser
  // ***********************************************************
  // Three stages; the level changes only when stages two and three agree
  // A glitch shorter than two cycles never reaches the suspend level
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      susp_sync_reg <= 3'h0;
      susp_reg      <= 1'b0;
    end else begin
      susp_sync_reg <= {susp_sync_reg[1:0], debug_suspend};
      if (susp_sync_reg[1] == susp_sync_reg[2]) begin
        susp_reg <= susp_sync_reg[2];
      end
    end
  end

  // ***********************************************************
  // Clock control, kept by power-on reset only
  // ***********************************************************
  // Divider and enable bits survive the hardware reset pin
  // A divide value of zero stops the timer clock altogether
  always @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      div_reg     <= `SST_DIV_RESET; // RQ2 RQ4
      dis_reg     <= 1'b0;
      susp_en_reg <= 1'b0;
    end else if (wr && paddr == `SST_OFF_CLC) begin
      div_reg     <= pwdata[`SST_CLC_DIV_HI:`SST_CLC_DIV_LO]; // RQ2
      dis_reg     <= pwdata[`SST_CLC_DIS_REQ]; // RQ7
      susp_en_reg <= pwdata[`SST_CLC_SUSP_EN]; // RQ7
    end
  end

  // Ticks stop while disabled or suspended
  assign run = !dis_reg && !(susp_en_reg && susp_reg); // RQ7

  // ***********************************************************
  // Counter
  // ***********************************************************
  // Software reset clears only when its request bit was set beforehand
  assign cnt_clear = wdt_rst || (sw_rst && rstreq_reg); // RQ3

  // Prescaler restarts with a clear, so the first tick follows a full period
  sst_tick #(
    .DIV_W (DIV_W)
  ) u_tick (
    .pclk  (pclk),
    .por_n (por_n),
    .clear (cnt_clear),
    .run   (run),
    .div   (div_reg),
    .tick  (tick)
  );

  // Next count: clear, else count on tick, wrapping silently
  always @* begin
    cnt_next = cnt_reg;
    if (cnt_clear) begin
      cnt_next = {`SST_CNT_W{1'b0}}; // RQ3
    end else if (tick) begin
      cnt_next = cnt_reg + {{(`SST_CNT_W-1){1'b0}}, 1'b1}; // RQ1 RQ13
    end
  end

  // Counter flops, cleared by power-on and never by presetn
  always @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      cnt_reg <= {`SST_CNT_W{1'b0}}; // RQ3 RQ4 RQ5
    end else begin
      cnt_reg <= cnt_next; // RQ1 RQ6
    end
  end

  // ***********************************************************
  // Compare units
  // ***********************************************************
  // Only counter bits 31:0 are compared, so a match recurs every 2^32 ticks
  sst_cmp #(
    .W (32)
  ) u_cmp0 (
    .pclk  (pclk),
    .por_n (por_n),
    .value (cnt_reg[31:0]),
    .cmp   (cmp0_reg),
    .hit   (hit0)
  );

  sst_cmp #(
    .W (32)
  ) u_cmp1 (
    .pclk  (pclk),
    .por_n (por_n),
    .value (cnt_reg[31:0]),
    .cmp   (cmp1_reg),
    .hit   (hit1)
  );

  // ***********************************************************
  // Read data mux
  // ***********************************************************
  // Four bits of shift per window step
  assign win_shift = {{(`SST_CNT_W-5){1'b0}}, win_idx, 2'b00};

  // Window value before it is cut to the 32-bit bus
  assign win_val   = cnt_reg >> win_shift;

  // Windows, capture, compares and control read back
  always @* begin
    rdata  = 32'h0;
    rd_hit = 1'b1;
    rd_win = 1'b0;
    case (paddr)
      `SST_OFF_CLC: begin
        rdata[`SST_CLC_DIS_REQ]                 = dis_reg;
        rdata[`SST_CLC_DIS_STAT]                = !run;
        rdata[`SST_CLC_SUSP_EN]                 = susp_en_reg;
        rdata[`SST_CLC_DIV_HI:`SST_CLC_DIV_LO]  = div_reg;
      end
      `SST_OFF_RSTREQ:  rdata[`SST_RSTREQ_BIT] = rstreq_reg;
      `SST_OFF_WIN6:    rdata = {8'h0, cnt_reg[`SST_CNT_W-1:`SST_WIN6_SHIFT]}; // RQ10 RQ12
      `SST_OFF_CAP:     rdata = {8'h0, cap_reg}; // RQ8
      `SST_OFF_CMP0:    rdata = cmp0_reg;
      `SST_OFF_CMP1:    rdata = cmp1_reg;
      `SST_OFF_IRQSTAT: rdata = {30'h0, stat_reg};
      `SST_OFF_IRQMASK: rdata = {30'h0, mask_reg};
      default: begin
        if (paddr >= `SST_OFF_WIN0 && paddr < `SST_OFF_WIN6 && paddr[1:0] == 2'b00) begin
          rdata  = win_val[31:0]; // RQ10 RQ12
          rd_win = 1'b1;
        end else begin
          rd_hit = 1'b0;
        end
      end
    endcase
  end

  // ***********************************************************
  // APB answer: one wait-free access phase
  // ***********************************************************
  // Read data sampled in setup, pready raised for the access phase
  // Unmapped or misaligned addresses raise pslverr and change nothing
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata      <= 32'h0;
      pready      <= 1'b0;
      pslverr     <= 1'b0;
      stat_rd_reg <= 2'h0;
    end else begin
      pready <= setup;
      if (setup) begin
        prdata      <= pwrite ? 32'h0 : rdata;
        pslverr     <= !rd_hit;
        stat_rd_reg <= (!pwrite && paddr == `SST_OFF_IRQSTAT) ? stat_reg : 2'h0;
      end else if (done) begin
        pslverr     <= 1'b0;
        stat_rd_reg <= 2'h0;
      end
    end
  end

  // ***********************************************************
  // Capture of the upper part
  // ***********************************************************
  // Latched with the same count the window read returns
  // A later capture read pairs with the last window read, not a live one
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_reg <= 24'h0;
    end else if (setup && !pwrite && rd_win) begin
      cap_reg <= cnt_reg[`SST_CNT_W-1:`SST_WIN6_SHIFT]; // RQ8
    end
  end

  // ***********************************************************
  // Writable control registers
  // ***********************************************************
  // Writes to windows, capture and status fall to the default and change nothing
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp0_reg   <= 32'h0;
      cmp1_reg   <= 32'h0;
      mask_reg   <= 2'h0;
      rstreq_reg <= 1'b0;
    end else if (wr) begin
      case (paddr)
        `SST_OFF_CMP0:    cmp0_reg   <= pwdata; // RQ11
        `SST_OFF_CMP1:    cmp1_reg   <= pwdata; // RQ11
        `SST_OFF_IRQMASK: mask_reg   <= pwdata[1:0];
        `SST_OFF_RSTREQ:  rstreq_reg <= pwdata[`SST_RSTREQ_BIT]; // RQ3
        default:          rstreq_reg <= rstreq_reg; // RQ6
      endcase
    end
  end

  // ***********************************************************
  // Interrupt status and output
  // ***********************************************************
  // Clear-on-read of the bits returned; a new event wins over the clear
  always @* begin
    stat_next = stat_reg;
    if (done && !pwrite && paddr == `SST_OFF_IRQSTAT) begin
      stat_next = stat_next & ~stat_rd_reg;
    end
    stat_next[`SST_IRQ_CMP0] = stat_next[`SST_IRQ_CMP0] | hit0; // RQ11
    stat_next[`SST_IRQ_CMP1] = stat_next[`SST_IRQ_CMP1] | hit1; // RQ11
  end

  // Status and level interrupt flops
  // irq follows the status at once, so a status read drops it in the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_reg <= 2'h0;
      irq      <= 1'b0;
    end else begin
      stat_reg <= stat_next;
      irq      <= |(stat_next & mask_reg); // RQ11
    end
  end
endmodule // sst_top

// *** tb/sst_chk.sv ***
// Checker of the system timer bus and interrupt ports
`timescale 1ns/10ps
`include "sst_regs.vh"
module sst_chk (
  // APB
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // Resets, suspend and interrupt
  input wire        por_n,
  input wire        wdt_rst,
  input wire        sw_rst,
  input wire        debug_suspend,
  input wire        irq
);
  // ****
  // Assertions
  // ****
  // Setup phase of a transfer and of a read
  wire setup = psel && !penable;
  wire rd_set = setup && !pwrite;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !por_n);
  rdy_after_setup_a: assert property (setup |=> pready)
    else $error("no ready after setup");
  rdy_one_cycle_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  err_with_rdy_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  unmapped_err_a: assert property (setup && paddr >= 8'h40 |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped address accepted");
  window_ok_a: assert property (setup && paddr >= `SST_OFF_WIN0 && paddr <= `SST_OFF_CAP && paddr[1:0] == 2'h0
    |=> !pslverr)
    else $error("window access refused");
  win6_top_a: assert property (rd_set && paddr == `SST_OFF_WIN6 |=> prdata[31:24] == 8'h00)
    else $error("top window upper bits set");
  cap_top_a: assert property (rd_set && paddr == `SST_OFF_CAP |=> prdata[31:24] == 8'h00)
    else $error("capture upper bits set");
  irq_reset_a: assert property (disable iff (!por_n) !presetn |-> !irq && !pready)
    else $error("output active in reset");
  rd_hold_a: assert property (pready |=> $stable(prdata))
    else $error("read data not held");
  // Main scenarios
  cover property (rd_set && paddr == `SST_OFF_CAP);
  cover property (pslverr);
  cover property ($rose(irq));
endmodule // sst_chk
bind sst_top sst_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .por_n, .wdt_rst, .sw_rst, .debug_suspend, .irq);

// *** tb/sst_top_tb.sv ***
// Self-checking testbench of the system timer
`timescale 1ns/10ps
`include "sst_regs.vh"
module sst_top_tb;
  // ****
  // Stimulus and checks
  // ****
  reg         pclk = 1'b0;
  reg         presetn = 1'b0;
  reg         por_n = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [7:0]  paddr = 8'h00;
  reg  [31:0] pwdata = 32'h0;
  reg         wdt_rst = 1'b0;
  reg         sw_rst = 1'b0;
  reg         debug_suspend = 1'b0;
  wire [31:0] prdata;
  wire        pready;
  wire        pslverr;
  wire        irq;
  reg  [31:0] rd, lo, hi, v;
  reg  [31:0] rs = 32'h0000_384e;
  reg         er;
  reg  [55:0] full;
  integer     num_errors = 0;
  integer     tests_run = 0;
  integer     i, d, e;
  sst_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .por_n, .wdt_rst, .sw_rst, .debug_suspend, .irq);
  // Clock of 10 ns
  initial begin
    forever #5 pclk = ~pclk;
  end
  // Xorshift source of stimulus
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  // Fewest ticks seen in a span of cycles
  function integer ticks(input integer cyc, input integer dv);
    ticks = cyc / dv;
  endfunction
  // One APB transfer, waits for ready
  task apb(input w, input [7:0] a, input [31:0] dt);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= dt;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
        @(posedge pclk);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // Clock control write
  task clc(input integer dv, input integer s, input integer ds);
    apb(1'b1, `SST_OFF_CLC, (dv << 8) | (s << 3) | ds);
  endtask
  // One-cycle pulse of a clearing reset
  task pulse(input w);
    begin
      @(posedge pclk);
      if (w) wdt_rst <= 1'b1;
      else sw_rst <= 1'b1;
      @(posedge pclk);
      wdt_rst <= 1'b0;
      sw_rst <= 1'b0;
    end
  endtask
  // Value compare
  task chk(input [63:0] nm, input [31:0] ex, input [31:0] s);
    begin
      tests_run = tests_run + 1;
      if (s !== ex) begin
        num_errors = num_errors + 1;
        $display("[ERR] %0s exp %h got %h", nm, ex, s);
      end
    end
  endtask
  // Verdict and end of run
  task summarize;
    begin
      $display("checks %0d errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  // Hang guard
  initial begin
    #500000;
    num_errors = num_errors + 1;
    summarize;
  end
  // Test sequence
  initial begin
    repeat (5) @(posedge pclk);
    por_n <= 1'b1;
    presetn <= 1'b1;
    apb(1'b0, `SST_OFF_CLC, 32'h0);
    chk("div_rst", 32'h2, (rd >> 8) & 32'h7);
    chk("irq_rst", 32'h0, irq);
    $display("test reset done");
    for (i = 0; i < 4; i = i + 1) begin
      rs = xs(rs);
      d = rs % 7 + 1;
      clc(d, 0, 0);
      apb(1'b0, `SST_OFF_WIN0, 32'h0);
      lo = rd;
      repeat (20 + i) @(posedge pclk);
      apb(1'b0, `SST_OFF_WIN0, 32'h0);
      v = rd - lo;
      e = ticks(23 + i, d);
      chk("rate", 32'h1, v == e || v == e + 1);
    end
    $display("test rate done");
    clc(0, 0, 0);
    apb(1'b0, `SST_OFF_WIN0, 32'h0);
    lo = rd;
    apb(1'b0, `SST_OFF_CAP, 32'h0);
    hi = rd;
    full = {hi[23:0], lo};
    chk("cap_top", 32'h0, hi[31:24]);
    for (i = 0; i < 7; i = i + 1) begin
      apb(1'b0, `SST_OFF_WIN0 + i * 4, 32'h0);
      chk("window", i < 6 ? full >> (4 * i) : full >> 32, rd);
    end
    rs = xs(rs);
    apb(1'b1, `SST_OFF_WIN0, rs);
    apb(1'b1, `SST_OFF_CAP, rs);
    apb(1'b0, `SST_OFF_WIN0, 32'h0);
    chk("ro", lo, rd);
    $display("test windows done");
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `SST_OFF_WIN0, 32'h0);
    chk("hw_rst", lo, rd);
    apb(1'b0, `SST_OFF_CLC, 32'h0);
    chk("hw_div", 32'h0, (rd >> 8) & 32'h7);
    pulse(1'b0);
    apb(1'b0, `SST_OFF_WIN0, 32'h0);
    chk("sw_noreq", lo, rd);
    apb(1'b1, `SST_OFF_RSTREQ, 32'h1);
    pulse(1'b0);
    apb(1'b0, `SST_OFF_WIN0, 32'h0);
    chk("sw_req", 32'h0, rd);
    clc(1, 0, 0);
    repeat (30) @(posedge pclk);
    pulse(1'b1);
    repeat (2) @(posedge pclk);
    apb(1'b0, `SST_OFF_WIN0, 32'h0);
    chk("wdt", 32'h1, rd > 0 && rd < 8);
    $display("test resets done");
    clc(1, 1, 0);
    debug_suspend <= 1'b1;
    repeat (8) @(posedge pclk);
    apb(1'b0, `SST_OFF_WIN0, 32'h0);
    lo = rd;
    repeat (5) @(posedge pclk);
    apb(1'b0, `SST_OFF_WIN0, 32'h0);
    chk("susp", lo, rd);
    debug_suspend <= 1'b0;
    repeat (8) @(posedge pclk);
    apb(1'b0, `SST_OFF_WIN0, 32'h0);
    chk("resume", 32'h1, rd != lo);
    clc(1, 0, 1);
    repeat (4) @(posedge pclk);
    apb(1'b0, `SST_OFF_WIN0, 32'h0);
    lo = rd;
    apb(1'b0, `SST_OFF_WIN0, 32'h0);
    chk("disable", lo, rd);
    apb(1'b0, `SST_OFF_CLC, 32'h0);
    chk("stopped", 32'h1, (rd >> 1) & 32'h1);
    clc(1, 0, 0);
    $display("test suspend done");
    apb(1'b0, `SST_OFF_WIN0, 32'h0);
    apb(1'b1, `SST_OFF_CMP0, rd + 40);
    apb(1'b0, `SST_OFF_IRQSTAT, 32'h0);
    apb(1'b1, `SST_OFF_IRQMASK, 32'h1);
    i = 0;
    while (irq !== 1'b1 && i < 100) begin
      i = i + 1;
      @(posedge pclk);
    end
    chk("irq", 32'h1, irq);
    apb(1'b0, `SST_OFF_IRQSTAT, 32'h0);
    chk("stat", 32'h1, rd & 32'h3);
    repeat (3) @(posedge pclk);
    chk("irq_clr", 32'h0, irq);
    apb(1'b0, `SST_OFF_WIN0, 32'h0);
    apb(1'b1, `SST_OFF_CMP1, rd + 30);
    repeat (60) @(posedge pclk);
    chk("masked", 32'h0, irq);
    apb(1'b0, `SST_OFF_IRQSTAT, 32'h0);
    chk("stat_msk", 32'h2, rd & 32'h3);
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", 32'h1, er);
    chk("err_data", 32'h0, rd);
    $display("test compare done");
    summarize;
  end
endmodule // sst_top_tb
